// ==== gds_pkg.sv ====
// gds_pkg: shared constants for the 16-bit serial frame link
// assumes a 20 MHz system clock on both ends
package gds_pkg;
  // ***************************
  // frame layout
  // ***************************
  localparam int FRAME_BITS = 16;
  localparam int CMD_BIT = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 8;
  localparam int DATA_HI = 7;
  localparam int DIAG_ADDR = 0;
  localparam int LOW_SUPPLY_BIT = 2;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // ***************************
  // timing
  // ***************************
  localparam int CLK_NS = 50;
  localparam int FRAME_GAP_NS = 400;
  localparam int LEAD_NS = 200;
  localparam int LAG_NS = 200;
  localparam int FRAME_GAP_CYC = (FRAME_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int LEAD_CYC = (LEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int LAG_CYC = (LAG_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_HALF_CYC = 8;
  // ***************************
  // host register map
  // ***************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TX_OFS = 8'h04;
  localparam logic [7:0] RX_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  localparam int START_BIT = 0;
  localparam int BUSY_BIT = 0;
  localparam int DONE_BIT = 1;
  typedef logic [15:0] gds_word_t;
endpackage

// ==== gds_if.sv ====
// gds_if: serial link between frame master and frame slave
// assumes the bench resolves the released data-out line
interface gds_if;
  logic sclk;
  logic chip_select_low;
  logic mosi;
  logic miso_drv;
  logic miso_oe;
  logic miso;
  // released line reads low here; the bench may model a real float
  assign miso = miso_oe & miso_drv;
  modport dev (input sclk, input chip_select_low, input mosi, output miso_drv, output miso_oe);
  modport host (output sclk, output chip_select_low, output mosi, input miso);
endinterface

// ==== gds_sync.sv ====
// gds_sync: two-flop synchroniser for asynchronous levels
// assumes each bit is an independent level
module gds_sync #(parameter int W = 1)
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_r <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // gds_sync

// ==== gds_dev.sv ====
// gds_dev: slave end of the 16-bit frame link with a small register store
// assumes link pins are asynchronous to mclk_i and sclk is well below mclk_i/4
import gds_pkg::*;

module gds_dev
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // link
  gds_if.dev link,
  // user side
  input wire logic [7:0] diag_i,
  output logic wr_stb_o,
  output logic [6:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic transfer_error_flag_o
);
  import gds_pkg::*;

  // ***************************
  // pin sampling
  // ***************************
  logic [2:0] pins_s;
  logic sclk_s, csn_s, mosi_s;
  logic sclk_d_r, csn_d_r;
  logic sclk_rise, sclk_fall, sel_fall, sel_rise;

  gds_sync #(.W(3)) u_sync
  (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .d_i({link.sclk, ~link.chip_select_low, link.mosi}),
    .q_o(pins_s)
  );

  // select passes inverted so the synchroniser's reset low reads as deselected;
  // otherwise a false select fall follows every reset and eats the first answer
  assign sclk_s = pins_s[2];
  assign csn_s = ~pins_s[1];
  assign mosi_s = pins_s[0];

  // idle level of select is high, so the delay flop resets high
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sclk_d_r <= 1'b0;
      csn_d_r <= 1'b1;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      csn_d_r <= csn_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;
  assign sel_fall = ~csn_s & csn_d_r;
  assign sel_rise = csn_s & ~csn_d_r;

  // ***************************
  // frame state
  // ***************************
  typedef enum logic [1:0] {GDS_IDLE = 2'b01, GDS_FRAME = 2'b10} gds_state_t;
  gds_state_t state_r;

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      state_r <= GDS_IDLE;
    else
    begin
      case (state_r)
        GDS_IDLE: if (sel_fall) state_r <= GDS_FRAME;
        GDS_FRAME: if (sel_rise) state_r <= GDS_IDLE;
        default: state_r <= GDS_IDLE;
      endcase
    end
  end

  // ***************************
  // register store and answer
  // ***************************
  logic [7:0] mem_r [0:127];
  logic ter_r;
  logic low_supply_r;
  logic [6:0] ans_addr_r;
  logic [7:0] diag_word, ans_data;
  gds_word_t ans_word;

  always_comb
  begin
    diag_word = diag_i;
    diag_word[LOW_SUPPLY_BIT] = diag_i[LOW_SUPPLY_BIT] | low_supply_r;
    if (ans_addr_r == 7'(DIAG_ADDR))
      ans_data = diag_word;
    else
      ans_data = mem_r[ans_addr_r];
    ans_word = {ter_r, ans_addr_r, ans_data};
  end

  // ***************************
  // shift buffer and counter
  // ***************************
  gds_word_t buf_r;
  logic [3:0] bit_cnt_r;
  logic seen_r;
  logic good_frame;

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      buf_r <= WORD_RST;
      bit_cnt_r <= 4'h0;
      seen_r <= 1'b0;
    end
    else if (state_r == GDS_IDLE)
    begin
      if (sel_fall)
      begin
        buf_r <= ans_word;
        bit_cnt_r <= 4'h0;
        seen_r <= 1'b0;
      end
    end
    else if (sclk_fall & ~csn_s)
    begin
      buf_r <= {buf_r[14:0], mosi_s};
      bit_cnt_r <= bit_cnt_r + 4'h1;
      seen_r <= 1'b1;
    end
  end

  assign good_frame = seen_r & (bit_cnt_r == 4'h0);

  // ***************************
  // command execution
  // ***************************
  logic wr_cmd;
  assign wr_cmd = buf_r[CMD_BIT];

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ter_r <= 1'b1;
      ans_addr_r <= 7'(DIAG_ADDR);
      wr_stb_o <= 1'b0;
      wr_addr_o <= 7'h00;
      wr_data_o <= 8'h00;
    end
    else
    begin
      wr_stb_o <= 1'b0;
      if (state_r == GDS_FRAME && sel_rise)
      begin
        ter_r <= ~good_frame;
        if (!good_frame)
          ans_addr_r <= 7'(DIAG_ADDR);
        else if (wr_cmd)
        begin
          ans_addr_r <= 7'(DIAG_ADDR);
          wr_stb_o <= 1'b1;
          wr_addr_o <= buf_r[ADDR_HI:ADDR_LO];
          wr_data_o <= buf_r[DATA_HI:0];
        end
        else
          ans_addr_r <= buf_r[ADDR_HI:ADDR_LO];
      end
    end
  end

  // store carries no reset; contents are defined only once written
  always_ff @(posedge mclk_i)
  begin
    if (state_r == GDS_FRAME && sel_rise && good_frame && wr_cmd)
      mem_r[buf_r[ADDR_HI:ADDR_LO]] <= buf_r[DATA_HI:0];
  end

  // power-on low-supply report lasts until the first answer leaves
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      low_supply_r <= 1'b1;
    else if (state_r == GDS_IDLE && sel_fall)
      low_supply_r <= 1'b0;
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      transfer_error_flag_o <= 1'b1;
    else
      transfer_error_flag_o <= ter_r;
  end

  // ***************************
  // data out pin
  // ***************************
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      link.miso_drv <= 1'b0;
      link.miso_oe <= 1'b0;
    end
    else if (state_r == GDS_IDLE)
    begin
      link.miso_drv <= 1'b0;
      link.miso_oe <= sel_fall;
    end
    else if (sel_rise)
    begin
      link.miso_oe <= 1'b0;
      link.miso_drv <= 1'b0;
    end
    else if (sclk_rise)
      link.miso_drv <= buf_r[FRAME_BITS-1];
  end
endmodule // gds_dev

// ==== gds_host.sv ====
// gds_host: frame master driven by software over APB
// assumes one slave on the link; the link clock is made here by a divider
import gds_pkg::*;

module gds_host
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // link
  gds_if.host link
);
  import gds_pkg::*;

  // ***************************
  // pin sampling
  // ***************************
  logic miso_s;
  gds_sync #(.W(1)) u_sync
  (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .d_i(link.miso),
    .q_o(miso_s)
  );

  // ***************************
  // frame sequencer
  // ***************************
  typedef enum logic [4:0] {H_IDLE = 5'b00001, H_LEAD = 5'b00010, H_CLK = 5'b00100,
    H_LAG = 5'b01000, H_GAP = 5'b10000} gds_hstate_t;
  gds_hstate_t state_r;
  logic [4:0] cnt_r;
  logic [4:0] bits_r;
  gds_word_t tx_r, sh_r, rx_r, rx_sh_r;
  logic done_r;
  logic start, done_clr, access, commit;

  assign access = psel_i & penable_i & ~pready_o;
  // writes land at the edge that completes the transfer, with ready high
  assign commit = psel_i & penable_i & pready_o;
  assign start = commit & pwrite_i & (paddr_i == CTRL_OFS) & pwdata_i[START_BIT] & (state_r == H_IDLE);
  assign done_clr = commit & pwrite_i & (paddr_i == STAT_OFS) & pwdata_i[DONE_BIT];

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_r <= H_IDLE;
      cnt_r <= 5'h00;
      bits_r <= 5'h00;
      sh_r <= WORD_RST;
      rx_sh_r <= WORD_RST;
      rx_r <= WORD_RST;
      link.sclk <= 1'b0;
      link.chip_select_low <= 1'b1;
      link.mosi <= 1'b0;
    end
    else
    begin
      case (state_r)
        H_IDLE:
          if (start)
          begin
            sh_r <= tx_r;
            link.mosi <= tx_r[FRAME_BITS-1];
            link.chip_select_low <= 1'b0;
            cnt_r <= 5'(LEAD_CYC);
            bits_r <= 5'h00;
            state_r <= H_LEAD;
          end
        H_LEAD:
          if (cnt_r == 5'h01)
          begin
            cnt_r <= 5'(SCLK_HALF_CYC);
            state_r <= H_CLK;
          end
          else
            cnt_r <= cnt_r - 5'h01;
        H_CLK:
          if (cnt_r != 5'h01)
            cnt_r <= cnt_r - 5'h01;
          else if (!link.sclk)
          begin
            link.sclk <= 1'b1;
            link.mosi <= sh_r[FRAME_BITS-1];
            cnt_r <= 5'(SCLK_HALF_CYC);
          end
          else
          begin
            link.sclk <= 1'b0;
            sh_r <= {sh_r[14:0], 1'b0};
            rx_sh_r <= {rx_sh_r[14:0], miso_s};
            bits_r <= bits_r + 5'h01;
            if (bits_r == 5'(FRAME_BITS - 1))
            begin
              cnt_r <= 5'(LAG_CYC);
              state_r <= H_LAG;
            end
            else
              cnt_r <= 5'(SCLK_HALF_CYC);
          end
        H_LAG:
          if (cnt_r == 5'h01)
          begin
            link.chip_select_low <= 1'b1;
            rx_r <= rx_sh_r;
            cnt_r <= 5'(FRAME_GAP_CYC);
            state_r <= H_GAP;
          end
          else
            cnt_r <= cnt_r - 5'h01;
        H_GAP:
          if (cnt_r == 5'h01)
            state_r <= H_IDLE;
          else
            cnt_r <= cnt_r - 5'h01;
        default: state_r <= H_IDLE;
      endcase
    end
  end

  // end of gap sets done; a set in the clearing cycle wins
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      done_r <= 1'b0;
    else if (state_r == H_GAP && cnt_r == 5'h01)
      done_r <= 1'b1;
    else if (done_clr)
      done_r <= 1'b0;
  end

  // ***************************
  // apb registers
  // ***************************
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      tx_r <= WORD_RST;
    else if (commit & pwrite_i & (paddr_i == TX_OFS))
      tx_r <= {pwdata_i[CMD_BIT], 1'b0, pwdata_i[ADDR_HI-1:0]};
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end
    else
    begin
      pready_o <= access;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
      if (access)
      begin
        case (paddr_i)
          CTRL_OFS: prdata_o <= 32'h00000000;
          TX_OFS: prdata_o <= {16'h0000, tx_r};
          RX_OFS: prdata_o <= {16'h0000, rx_r};
          STAT_OFS: prdata_o <= {30'h00000000, done_r, state_r != H_IDLE};
          default: pslverr_o <= 1'b1;
        endcase
      end
    end
  end
endmodule // gds_host

// ==== gds_checker.sv ====
// gds_checker: timing and framing assertions on the host-to-device link
// assumes both link ends are design code and share mclk_i and reset_i
module gds_checker
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // link
  input wire logic sclk,
  input wire logic chip_select_low,
  input wire logic mosi,
  input wire logic miso_drv,
  input wire logic miso_oe,
  input wire logic miso
);
  // ****
  // sclk rises counted per frame
  // ****
  logic sclk_r;
  logic [5:0] rise_r;
  always_ff @(posedge mclk_i or posedge reset_i)
    if (reset_i)
      sclk_r <= 1'b0;
    else
      sclk_r <= sclk;
  always_ff @(posedge mclk_i or posedge reset_i)
    if (reset_i)
      rise_r <= 6'h00;
    else if (chip_select_low)
      rise_r <= 6'h00;
    else if (sclk && !sclk_r)
      rise_r <= rise_r + 6'h01;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  // ****
  // properties
  // ****
  property p_release; $rose(chip_select_low) |-> ##[1:5] !miso_oe; endproperty
  a_release: assert property (p_release) else $error("data out not released");
  property p_idle; chip_select_low [*6] |-> !miso_oe; endproperty
  a_idle: assert property (p_idle) else $error("data out driven while deselected");
  property p_drive; $fell(chip_select_low) |-> ##5 (miso_oe && !miso_drv); endproperty
  a_drive: assert property (p_drive) else $error("data out not driven low at frame start");
  property p_lead; $fell(chip_select_low) |-> !sclk [*4]; endproperty
  a_lead: assert property (p_lead) else $error("link clock not low at frame start");
  property p_count; $rose(chip_select_low) |-> rise_r == 6'h10; endproperty
  a_count: assert property (p_count) else $error("frame clock count wrong");
  property p_gap; $rose(chip_select_low) |-> chip_select_low [*8]; endproperty
  a_gap: assert property (p_gap) else $error("frame gap too short");
  // a bit may only move while sclk is high, so it is stable at the sampling fall
  property p_shift; miso_oe && $past(miso_oe) && $changed(miso_drv) |-> sclk; endproperty
  a_shift: assert property (p_shift) else $error("data out moved outside clock high");
  property p_top_addr; !chip_select_low && $fell(sclk) && rise_r == 6'h02 |-> !mosi; endproperty
  a_top_addr: assert property (p_top_addr) else $error("reserved address bit sent high");
  cover property ($rose(chip_select_low));
  cover property (miso_oe && miso);
  cover property (rise_r == 6'h10);
endmodule // gds_checker

// ==== tb_top.sv ====
// tb_top: host and device joined on one link, a second device on a bench-driven link
// assumes a 20 MHz clock for all ends; bench link clock period 400 ns
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gds_pkg::*;
  localparam logic [15:0] TXS [6] = '{16'h85A5, 16'h45FF, 16'hC17E, 16'h0100, 16'h0000, 16'h0000};
  localparam logic [15:0] EXP [6] = '{16'h803C, 16'h0038, 16'h05A5, 16'h0038, 16'h017E, 16'h0038};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [7:0] diag = 8'h38;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, stb, stb2, transfer_error_flag, ter2, e;
  logic [6:0] wa;
  logic [7:0] wd;
  logic [15:0] r, a;
  int n_fail = 0, n_checks = 0, n_wr = 0, n_wr2 = 0;
  gds_if l1();
  gds_if l2();
  always #25 mclk = ~mclk;
  gds_host gds_host_i (.mclk_i(mclk), .reset_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link(l1));
  gds_dev gds_dev_i (.mclk_i(mclk), .reset_i(rst), .link(l1), .diag_i(diag), .wr_stb_o(stb),
    .wr_addr_o(wa), .wr_data_o(wd), .transfer_error_flag_o(transfer_error_flag));
  gds_dev gds_dev_b_i (.mclk_i(mclk), .reset_i(rst), .link(l2), .diag_i(diag), .wr_stb_o(stb2),
    .wr_addr_o(), .wr_data_o(), .transfer_error_flag_o(ter2));
  gds_checker gds_checker_i (.mclk_i(mclk), .reset_i(rst), .sclk(l1.sclk), .chip_select_low(l1.chip_select_low),
    .mosi(l1.mosi), .miso_drv(l1.miso_drv), .miso_oe(l1.miso_oe), .miso(l1.miso));
  always @(posedge mclk)
  begin
    if (stb === 1'b1)
      n_wr++;
    if (stb2 === 1'b1)
      n_wr2++;
  end
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk_w({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic hang(input int k);
    if (k >= 200)
    begin
      n_fail++;
      $display("unexpected at %0t: wait ran out", $time);
      end_of_test;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] rd,
    output logic er);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (pready !== 1'b1 && k < 200);
    hang(k);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic frame(input logic [15:0] w, output logic [15:0] rx);
    int k;
    k = 0;
    apb(1'b1, TX_OFS, {16'h0000, w}, q, e);
    apb(1'b1, CTRL_OFS, 32'h00000001, q, e);
    do
    begin
      apb(1'b0, STAT_OFS, 32'h0, q, e);
      k++;
    end
    while (q[DONE_BIT] !== 1'b1 && k < 200);
    hang(k);
    apb(1'b1, STAT_OFS, 32'h00000002, q, e);
    apb(1'b0, RX_OFS, 32'h0, q, e);
    rx = q[15:0];
  endtask
  // answer sampled late in the low half, well clear of the resync delay
  task automatic xfer2(input logic [15:0] w, input int n, output logic [15:0] ans);
    ans = 16'h0000;
    @(posedge mclk);
    l2.chip_select_low <= 1'b0;
    l2.mosi <= w[15];
    repeat (4) @(posedge mclk);
    for (int i = 0; i < n; i++)
    begin
      l2.sclk <= 1'b1;
      l2.mosi <= w[15 - i];
      repeat (4) @(posedge mclk);
      l2.sclk <= 1'b0;
      repeat (4) @(posedge mclk);
      ans = {ans[14:0], l2.miso};
    end
    l2.chip_select_low <= 1'b1;
    l2.mosi <= ~l2.mosi;
    repeat (8) @(posedge mclk);
  endtask
  initial
  begin
    l2.sclk = 1'b0;
    l2.chip_select_low = 1'b1;
    l2.mosi = 1'b0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    for (int f = 0; f < 6; f++)
    begin
      frame(TXS[f], r);
      chk_w(r, EXP[f]);
    end
    chk_w(16'(n_wr), 16'h0002);
    chk_w({1'b0, wa, wd}, 16'h017E);
    chk_b(transfer_error_flag, 1'b0);
    $display("test frames done");
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk_b(e, 1'b1);
    chk_w(q[15:0], 16'h0000);
    $display("test apb done");
    xfer2(16'h8203, 16, a);
    chk_w(a, 16'h803C);
    xfer2(16'h8255, 15, a);
    xfer2(16'h8255, 0, a);
    chk_w(16'(n_wr2), 16'h0001);
    chk_b(ter2, 1'b1);
    xfer2(16'h0200, 16, a);
    chk_w(a, 16'h8038);
    xfer2(16'h0000, 16, a);
    chk_w(a, 16'h0203);
    chk_b(ter2, 1'b0);
    $display("test error link done");
    end_of_test;
  end
endmodule // tb_top
